// File: hw/emb_builder.sv
// Emergency frame builder with AHB-Lite register slave
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module emb_builder
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic [emb_pkg::NKIND-1:0] fault_evt,
    input  wire emb_pkg::emb_fault_s   fault_info,
    output logic                       can_reinit,
    output emb_pkg::emb_frame_s        frame,
    output logic                       frame_valid,
    input  wire logic                  frame_ready
);

    localparam int NK = emb_pkg::NKIND;

    // Lowest pending kind
    function automatic logic [3:0] first_set(input logic [NK-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NK - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Error code of a kind
    function automatic logic [15:0] code_of(input logic [3:0] k);
        logic [15:0] c;
        case (k)
            emb_pkg::K_CAN_COMM:   c = emb_pkg::CODE_CAN_COMM;
            emb_pkg::K_BUF_OVER:   c = emb_pkg::CODE_BUF_OVER;
            emb_pkg::K_GUARD:      c = emb_pkg::CODE_GUARD;
            emb_pkg::K_RPDO_SHORT: c = emb_pkg::CODE_RPDO;
            emb_pkg::K_BOOT_NOAPP: c = emb_pkg::CODE_NOAPP;
            default:               c = emb_pkg::CODE_MANUF;
        endcase
        return c;
    endfunction

    // Five detail bytes (3..7) for a kind from the info snapshot
    function automatic logic [4:0][7:0] detail_of(
        input logic [3:0]          k,
        input emb_pkg::emb_fault_s f
    );
        logic [4:0][7:0] d;
        d = '0;
        case (k)
            emb_pkg::K_CAN_COMM:
            begin
                d[0] = f.can_int;
                d[1] = f.can_mode;
                d[2] = f.can_err_count;
            end
            emb_pkg::K_RPDO_SHORT: d[0] = f.rpdo_min_dlc;
            emb_pkg::K_SLAVE_NR:   d[0] = emb_pkg::B3_SLAVE_NR;
            emb_pkg::K_CRC:
            begin
                d[0] = emb_pkg::B3_CRC;
                d[1] = f.crc_slave_flash ? emb_pkg::CRC_SLAVE
                                         : emb_pkg::CRC_MASTER;
            end
            emb_pkg::K_EE_WRITE:
            begin
                d[0] = emb_pkg::B3_EE_WRITE;
                d[1] = f.ee_block_index;
                d[2] = f.ee_write_size;
            end
            emb_pkg::K_EE_READ:
            begin
                d[0] = emb_pkg::B3_EE_READ;
                d[1] = f.ee_block_index;
                d[2] = f.ee_read_err_id;
            end
            emb_pkg::K_IRREG_RST:
            begin
                d[0] = emb_pkg::B3_IRREG_RST;
                d[1] = f.reset_cause_flags;
            end
            emb_pkg::K_BOOT_CTRL:
            begin
                d[0] = emb_pkg::B3_BOOT;
                d[1] = emb_pkg::B4_BOOT_CTRL;
                d[2] = emb_pkg::B5_BOOT_CTRL;
                d[3] = f.reset_cause_flags;
                d[4] = emb_pkg::B7_BOOT_CTRL;
            end
            emb_pkg::K_BOOT_NOAPP:
            begin
                d[0] = emb_pkg::B3_BOOT;
                d[1] = emb_pkg::B_NOAPP;
                d[2] = emb_pkg::B_NOAPP;
            end
            default:               d = '0;
        endcase
        return d;
    endfunction

    // Registers
    logic [6:0]              node_reg;
    logic                    en_reg;
    logic [7:0]              summary_reg;
    logic [7:0]              summary_next;
    logic [NK-1:0]           pend_reg;
    logic [NK-1:0]           pend_next;
    logic [4:0][7:0]         detail_reg [NK];
    emb_pkg::emb_state_e     state_reg;
    emb_pkg::emb_state_e     state_next;
    emb_pkg::emb_frame_s     frame_reg;
    logic [31:0]             count_reg;
    logic                    reinit_reg;
    logic                    wr_pend_reg;
    logic [15:0]             wr_addr_reg;
    logic [31:0]             rdata_reg;

    // Bus decode
    wire        bus_take = hsel & htrans[1] & hready;
    wire [15:0] a_addr   = haddr[15:0];
    wire        a_hit_ctrl = a_addr == emb_pkg::ADDR_CTRL;
    wire        a_hit_stat = a_addr == emb_pkg::ADDR_STATUS;
    wire        a_hit_cnt  = a_addr == emb_pkg::ADDR_FRAME_COUNT;
    wire        a_hit_sum  = a_addr == emb_pkg::ADDR_ERROR_SUMMARY;
    wire        w_ctrl = wr_pend_reg & (wr_addr_reg == emb_pkg::ADDR_CTRL);
    wire        w_sset = wr_pend_reg
                         & (wr_addr_reg == emb_pkg::ADDR_SUMMARY_SET);

    wire [31:0] ctrl_word = {23'h000000, en_reg, 1'b0, node_reg};
    wire [31:0] stat_word = {15'h0000, frame_valid, 5'h00, pend_reg};
    wire [31:0] sum_word  = {24'h000000, summary_reg};
    wire [31:0] rd_mux =
        a_hit_ctrl ? ctrl_word :
        a_hit_stat ? stat_word :
        a_hit_cnt  ? count_reg :
        a_hit_sum  ? sum_word  : 32'h00000000;

    // Summary bits that each new fault sets
    wire comm_evt  = |fault_evt[emb_pkg::K_RPDO_SHORT:emb_pkg::K_CAN_COMM];
    wire manuf_evt = |fault_evt[NK-1:emb_pkg::K_SLAVE_NR];
    wire [7:0] hw_sum_set = {manuf_evt, 2'b00, comm_evt, 3'b000,
                             |fault_evt};
    wire [7:0] sw_sum_set = w_sset ? (hwdata[7:0] & emb_pkg::SUM_SW_MASK)
                                   : 8'h00;
    // Reserved bit forced low; no clear path short of reset
    assign summary_next = (summary_reg | hw_sum_set | sw_sum_set)
                          & ~(8'h01 << emb_pkg::SUM_RESERVED);

    // Frame assembly
    wire [3:0]      pick      = first_set(pend_reg);
    wire            load      = (state_reg == emb_pkg::S_IDLE) & en_reg
                                & (|pend_reg);
    wire [NK-1:0]   grant     = load ? (NK'(1) << pick) : '0;
    wire [15:0]     pick_code = code_of(pick);
    // New event for the same kind in the granted cycle stays pending
    assign pend_next = (pend_reg & ~grant) | fault_evt;

    emb_pkg::emb_frame_s frame_next;
    assign frame_next.cob_id = emb_pkg::COB_EMCY_BASE
                               + {4'h0, node_reg};
    assign frame_next.dlc    = emb_pkg::FRAME_DLC;
    assign frame_next.data[0] = pick_code[7:0];
    assign frame_next.data[1] = pick_code[15:8];
    assign frame_next.data[2] = summary_reg;
    assign frame_next.data[7:3] = detail_reg[pick];

    always_comb
    begin
        case (state_reg)
            emb_pkg::S_IDLE: state_next = load ? emb_pkg::S_HOLD
                                               : emb_pkg::S_IDLE;
            emb_pkg::S_HOLD: state_next = frame_ready ? emb_pkg::S_IDLE
                                                      : emb_pkg::S_HOLD;
            default:         state_next = emb_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            node_reg    <= emb_pkg::NODE_RESET;
            en_reg      <= emb_pkg::EN_RESET;
            summary_reg <= emb_pkg::SUM_RESET;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 16'h0000;
            rdata_reg   <= 32'h00000000;
        end
        else
        begin
            summary_reg <= summary_next;
            wr_pend_reg <= bus_take & hwrite;
            wr_addr_reg <= a_addr;
            if (bus_take & !hwrite)
            begin
                rdata_reg <= rd_mux;
            end
            if (w_ctrl)
            begin
                node_reg <= hwdata[emb_pkg::CTRL_NODE_LSB +:
                                   emb_pkg::CTRL_NODE_W];
                en_reg   <= hwdata[emb_pkg::CTRL_EN_BIT];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_reg   <= '0;
            state_reg  <= emb_pkg::S_IDLE;
            frame_reg  <= '0;
            count_reg  <= 32'h00000000;
            reinit_reg <= 1'b0;
        end
        else
        begin
            pend_reg   <= pend_next;
            state_reg  <= state_next;
            reinit_reg <= fault_evt[emb_pkg::K_GUARD];
            if (load)
            begin
                frame_reg <= frame_next;
            end
            if ((state_reg == emb_pkg::S_HOLD) & frame_ready)
            begin
                count_reg <= count_reg + 32'h00000001;
            end
        end
    end

    // Detail snapshot per kind, taken with its event
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NK; i++)
            begin
                detail_reg[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < NK; i++)
            begin
                if (fault_evt[i])
                begin
                    detail_reg[i] <= detail_of(4'(i), fault_info);
                end
            end
        end
    end

    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = rdata_reg;
    assign frame       = frame_reg;
    assign frame_valid = state_reg == emb_pkg::S_HOLD;
    assign can_reinit  = reinit_reg;

endmodule

`default_nettype wire

// File: hw/emb_pkg.sv
// Package for the emergency message builder: constants, types, register map
package emb_pkg;

    localparam int NKIND = 11;

    // Fault kinds, lower code wins when several are pending
    typedef enum logic [3:0] {
        K_CAN_COMM   = 4'h0,
        K_BUF_OVER   = 4'h1,
        K_GUARD      = 4'h2,
        K_RPDO_SHORT = 4'h3,
        K_SLAVE_NR   = 4'h4,
        K_CRC        = 4'h5,
        K_EE_WRITE   = 4'h6,
        K_EE_READ    = 4'h7,
        K_IRREG_RST  = 4'h8,
        K_BOOT_CTRL  = 4'h9,
        K_BOOT_NOAPP = 4'hA
    } emb_kind_e;

    typedef enum logic [0:0] {
        S_IDLE = 1'b0,
        S_HOLD = 1'b1
    } emb_state_e;

    // Frame identifier base and length
    localparam logic [10:0] COB_EMCY_BASE = 11'h080;
    localparam logic [3:0]  FRAME_DLC     = 4'h8;

    // Emergency error codes
    localparam logic [15:0] CODE_CAN_COMM  = 16'h8100;
    localparam logic [15:0] CODE_BUF_OVER  = 16'h8110;
    localparam logic [15:0] CODE_GUARD     = 16'h8130;
    localparam logic [15:0] CODE_RPDO      = 16'h8210;
    localparam logic [15:0] CODE_MANUF     = 16'h5000;
    localparam logic [15:0] CODE_NOAPP     = 16'h6000;

    // Byte 3 selectors and fixed detail bytes
    localparam logic [7:0] B3_SLAVE_NR  = 8'h20;
    localparam logic [7:0] B3_CRC       = 8'h30;
    localparam logic [7:0] B3_EE_WRITE  = 8'h41;
    localparam logic [7:0] B3_EE_READ   = 8'h42;
    localparam logic [7:0] B3_IRREG_RST = 8'hF0;
    localparam logic [7:0] B3_BOOT      = 8'hFE;
    localparam logic [7:0] B4_BOOT_CTRL = 8'h01;
    localparam logic [7:0] B5_BOOT_CTRL = 8'h28;
    localparam logic [7:0] B7_BOOT_CTRL = 8'h00;
    localparam logic [7:0] B_NOAPP      = 8'hAA;
    localparam logic [7:0] CRC_MASTER   = 8'h01;
    localparam logic [7:0] CRC_SLAVE    = 8'h02;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;

    // Parameter block index encoding
    localparam logic [7:0] BLK_TPDO     = 8'h00;
    localparam logic [7:0] BLK_RPDO     = 8'h01;
    localparam logic [7:0] BLK_GUARD    = 8'h02;
    localparam logic [7:0] BLK_CANCFG   = 8'h03;
    localparam logic [7:0] BLK_APPCFG   = 8'h04;
    localparam logic [7:0] BLK_CALIB    = 8'hFE;
    localparam logic [7:0] BLK_SERIAL   = 8'hFF;

    // EEPROM read error ids
    localparam logic [7:0] EERD_CRC     = 8'h01;
    localparam logic [7:0] EERD_LENGTH  = 8'h02;
    localparam logic [7:0] EERD_INFO    = 8'h04;

    // Reset cause flag encoding
    localparam logic [7:0] RC_POWER_ON  = 8'h01;
    localparam logic [7:0] RC_EXTERNAL  = 8'h02;
    localparam logic [7:0] RC_BROWN_OUT = 8'h04;
    localparam logic [7:0] RC_WATCHDOG  = 8'h08;
    localparam logic [7:0] RC_JTAG      = 8'h10;
    localparam logic [7:0] RC_JTAG_OFF  = 8'h80;

    // Error summary bit positions
    localparam int SUM_GENERIC  = 0;
    localparam int SUM_CURRENT  = 1;
    localparam int SUM_VOLTAGE  = 2;
    localparam int SUM_TEMP     = 3;
    localparam int SUM_COMM     = 4;
    localparam int SUM_PROFILE  = 5;
    localparam int SUM_RESERVED = 6;
    localparam int SUM_MANUF    = 7;
    localparam logic [7:0] SUM_SW_MASK = 8'h2E;
    localparam logic [7:0] SUM_RESET   = 8'h00;

    // Register map: summary index is not word aligned, so byte addr = 4*idx
    localparam logic [15:0] IDX_ERROR_SUMMARY  = 16'h1001;
    localparam logic [15:0] ADDR_ERROR_SUMMARY = 16'h4004;
    localparam logic [15:0] ADDR_CTRL          = 16'h0000;
    localparam logic [15:0] ADDR_STATUS        = 16'h0004;
    localparam logic [15:0] ADDR_SUMMARY_SET   = 16'h0008;
    localparam logic [15:0] ADDR_FRAME_COUNT   = 16'h000C;

    // Control fields
    localparam int CTRL_NODE_LSB = 0;
    localparam int CTRL_NODE_W   = 7;
    localparam int CTRL_EN_BIT   = 8;
    localparam logic [6:0] NODE_RESET = 7'h00;
    localparam logic       EN_RESET   = 1'b1;
    localparam int STATUS_VALID_BIT = 16;

    typedef struct packed {
        logic [7:0] can_int;
        logic [7:0] can_mode;
        logic [7:0] can_err_count;
        logic [7:0] rpdo_min_dlc;
        logic       crc_slave_flash;
        logic [7:0] ee_block_index;
        logic [7:0] ee_write_size;
        logic [7:0] ee_read_err_id;
        logic [7:0] reset_cause_flags;
    } emb_fault_s;

    typedef struct packed {
        logic [10:0]     cob_id;
        logic [3:0]      dlc;
        logic [7:0][7:0] data;
    } emb_frame_s;

endpackage

// File: verification/emb_builder_sva.sv
// Port assertions for the emergency frame builder
`timescale 1ns/1ps
`default_nettype none
module emb_builder_sva
(
    input wire logic                       hclk,
    input wire logic                       hresetn,
    input wire logic                       hsel,
    input wire logic [31:0]                haddr,
    input wire logic [1:0]                 htrans,
    input wire logic                       hwrite,
    input wire logic [2:0]                 hsize,
    input wire logic [31:0]                hwdata,
    input wire logic                       hready,
    input wire logic                       hreadyout,
    input wire logic                       hresp,
    input wire logic [31:0]                hrdata,
    input wire logic [emb_pkg::NKIND-1:0]  fault_evt,
    input wire emb_pkg::emb_fault_s        fault_info,
    input wire logic                       can_reinit,
    input wire emb_pkg::emb_frame_s        frame,
    input wire logic                       frame_valid,
    input wire logic                       frame_ready
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    hold_frame_a:
    assert property (frame_valid && !frame_ready |=> frame_valid
        && $stable(frame)) else $error("frame changed before accept");
    frame_gap_a:
    assert property (frame_valid && frame_ready |=> !frame_valid)
        else $error("no idle cycle after accept");
    frame_len_a:
    assert property (frame_valid |-> frame.dlc == 4'h8)
        else $error("frame length not eight");
    summary_bits_a:
    assert property (frame_valid |-> !frame.data[2][6] && frame.data[2][0])
        else $error("summary byte bits wrong");
    reinit_cause_a:
    assert property (can_reinit |-> $past(fault_evt[2]))
        else $error("reinit without guard timeout");
    reinit_next_a:
    assert property (fault_evt[2] |=> can_reinit)
        else $error("guard timeout gave no reinit");
    code_order_a:
    assert property (frame_valid |-> frame.data[1] inside
        {8'h81, 8'h82, 8'h50, 8'h60}) else $error("code byte order wrong");
    noapp_a:
    assert property (frame_valid && frame.data[1] == 8'h60
        |-> frame.data[7:3] == 40'h0000AAAAFE) else $error("no app detail");
    boot_a:
    assert property (frame_valid && frame.data[1] == 8'h50
        && frame.data[3] == 8'hFE |-> frame.data[5:4] == 16'h2801
        && frame.data[7] == 8'h00) else $error("boot detail wrong");
    slave_a:
    assert property (frame_valid && frame.data[1] == 8'h50
        && frame.data[3] == 8'h20 |-> frame.data[7:4] == 32'h0)
        else $error("slave detail wrong");
    bus_okay_a:
    assert property (hreadyout && !hresp) else $error("bus not ready");

    cover property (frame_valid && !frame_ready);
    cover property (can_reinit);
    cover property (frame_valid && frame.data[1] == 8'h60);
endmodule

bind emb_builder emb_builder_sva u_sva
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fault_evt(fault_evt), .fault_info(fault_info),
    .can_reinit(can_reinit), .frame(frame), .frame_valid(frame_valid),
    .frame_ready(frame_ready)
);
`default_nettype wire

// File: verification/emb_builder_tb.sv
// Self-checking bench for the emergency frame builder
`timescale 1ns/1ps
`default_nettype none
module emb_builder_tb;
    logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic                can_reinit, frame_valid, frame_ready;
    logic [31:0]         haddr, hwdata, hrdata, rd;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [3:0]          stall;
    logic [10:0]         fault_evt;
    logic [15:0]         got_n;
    logic [7:0]          exp_sum;
    emb_pkg::emb_fault_s fi;
    emb_pkg::emb_frame_s frame, got;
    int                  mismatches, compares;

    localparam logic [15:0] CODES [11] = '{16'h8100, 16'h8110, 16'h8130,
        16'h8210, 16'h5000, 16'h5000, 16'h5000, 16'h5000, 16'h5000,
        16'h5000, 16'h6000};
    // Detail bytes 7..3 for the fixed fault snapshot below
    localparam logic [39:0] DET [11] = '{40'hC3B2A1, 40'h0, 40'h0,
        40'h04, 40'h20, 40'h0230, 40'h10FE41, 40'h02FE42, 40'h08F0,
        40'h00082801FE, 40'hAAAAFE};

    emb_builder u_dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .fault_evt(fault_evt), .fault_info(fi),
        .can_reinit(can_reinit), .frame(frame),
        .frame_valid(frame_valid), .frame_ready(frame_ready)
    );
    emb_host_model u_host
    (
        .hclk(hclk), .hresetn(hresetn), .frame(frame),
        .frame_valid(frame_valid), .stall(stall),
        .frame_ready(frame_ready), .got(got), .got_n(got_n)
    );

    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #20000;
        mismatches++;
        test_done;
    end

    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {16'h0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic chk_reg(input logic [15:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        compares++;
        if (rd !== e)
        begin
            mismatches++;
            $display("CHECK FAILED reg %h exp %h got %h", a, e, rd);
        end
    endtask

    task automatic chk_frm(input int k, input logic [39:0] d);
        emb_pkg::emb_frame_s e;
        e = {11'h0A5, 4'h8, d, exp_sum, CODES[k]};
        compares++;
        if (got !== e)
        begin
            mismatches++;
            $display("CHECK FAILED frame %0d exp %h got %h", k, e, got);
        end
    endtask

    task automatic fire(input logic [10:0] m);
        fault_evt <= m;
        @(posedge hclk);
        fault_evt <= 11'h000;
    endtask

    task automatic take(input int k, input logic [39:0] d);
        logic [15:0] n;
        n = got_n;
        for (int i = 0; i < 40 && got_n == n; i++) @(posedge hclk);
        // A frame that never arrives is a mismatch, not a stale compare
        compares++;
        if (got_n == n)
        begin
            mismatches++;
            $display("CHECK FAILED frames exp %0d got %0d", n + 16'h0001,
                     got_n);
        end
        chk_frm(k, d);
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        fault_evt = 11'h000;
        fi = {8'hA1, 8'hB2, 8'hC3, 8'h04, 1'b1, 8'hFE, 8'h10, 8'h02, 8'h08};
        stall = 4'h0;
        exp_sum = 8'h00;
        mismatches = 0;
        compares = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_reg(16'h4004, 32'h0);
        bus(1'b1, 16'h0008, 32'hFF);
        bus(1'b1, 16'h4004, 32'hFF);
        exp_sum = 8'h2E;
        chk_reg(16'h4004, 32'h2E);
        chk_reg(16'h0010, 32'h0);
        bus(1'b1, 16'h0000, 32'h125);
        $display("test registers done");
        // Every fault kind once, host stalling 0 to 3 cycles
        for (int k = 0; k < 11; k++)
        begin
            stall <= 4'(k % 4);
            exp_sum = exp_sum | 8'h01 | (k < 4 ? 8'h10 : 8'h80);
            fire(11'(1 << k));
            take(k, DET[k]);
        end
        chk_reg(16'h000C, 32'h0000000B);
        $display("test frames done");
        // Disabled: both stay pending, then lowest kind goes first
        bus(1'b1, 16'h0000, 32'h025);
        stall <= 4'h2;
        fire(11'h00A);
        repeat (8) @(posedge hclk);
        chk_reg(16'h0004, 32'h0000000A);
        bus(1'b1, 16'h0000, 32'h125);
        take(1, DET[1]);
        take(3, DET[3]);
        chk_reg(16'h000C, 32'h0000000D);
        chk_reg(16'h4004, 32'hBF);
        $display("test enable done");
        // Master flash CRC fault reports 1 in byte 4
        fi.crc_slave_flash <= 1'b0;
        fire(11'h020);
        take(5, 40'h0130);
        chk_reg(16'h000C, 32'h0000000E);
        $display("test master crc done");
        test_done;
    end
endmodule
`default_nettype wire

// File: verification/emb_host_model.sv
// Host side model: takes emergency frames after a set stall
`timescale 1ns/1ps
`default_nettype none
module emb_host_model
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire emb_pkg::emb_frame_s frame,
    input  wire logic                frame_valid,
    input  wire logic [3:0]          stall,
    output logic                     frame_ready,
    output emb_pkg::emb_frame_s      got,
    output logic [15:0]              got_n
);
    logic [3:0] wait_reg;

    // Slow host: ready only once the stall has run out
    assign frame_ready = frame_valid && (wait_reg >= stall);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wait_reg <= 4'h0;
            got      <= '0;
            got_n    <= 16'h0;
        end
        else if (frame_ready)
        begin
            wait_reg <= 4'h0;
            got      <= frame;
            got_n    <= got_n + 16'h1;
        end
        else if (frame_valid)
            wait_reg <= wait_reg + 4'h1;
    end
endmodule
`default_nettype wire
